// >>> design/fsp_self_prog.sv
// Flash self-programming front end: control register, command windows, page buffer,
// fuse and lock readback, and timed erase and write of a small flash array.
// Assumes the CPU core issues one-cycle store and load program strobes with the pointer.
//
// Overview of operation
// [R1] Pointer low bits pick word in page, high bits pick the page.
// [R2] Software must give the same page for erase and for write.
// [R3] Load reads bytes; pointer bit zero picks low or high byte.
// [R4] EEPROM write busy blocks programming commands and fuse or lock reads.
// [R5] Software should poll EEPROM busy before writing the control register.
// [R6] Pointer 0x0001 plus fuse read select returns lock bits within three cycles.
// [R7] Select and enable clear on read done, three-cycle load or four-cycle store timeout.
// [R8] With select and enable clear, loads are plain flash byte reads.
// [R9] Armed read at pointer 0x0000 returns the fuse low byte.
// [R10] Armed read at pointer 0x0003 returns the fuse high byte.
// [R11] Armed read at pointer 0x0002 returns the fuse extended byte.
// [R12] Programmed bits read as zero, unprogrammed as one.
// [R13] A flash write in progress completes even across reset.
// [R14] Erase, write and lock write last between 3.7 and 4.5 ms.
// [R15] Read-while-write busy bit always reads zero.
// [R16] Software waits for enable clear before the next store command.
// [R17] Code 00000011 then store within four cycles erases the page, CPU halted.
// [R18] Code 00000001 then store within four cycles loads a buffer word.
// [R19] Code 00000101 then store within four cycles writes the page, CPU halted.
// [R20] Control writes other than the five legal low patterns are ignored.
// [R21] Busy holds through the timed operation; no new commands until done.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module fsp_self_prog
    import fsp_pkg::*;
#(
    parameter int unsigned WORD_BITS   = 5,
    parameter int unsigned PAGE_BITS   = 4,
    parameter int unsigned WRITE_COUNT = WRITE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        csr_we,
    input  wire logic        csr_re,
    input  wire logic [7:0]  csr_wdata,
    output logic      [7:0]  csr_rdata,
    input  wire logic        store_req,
    input  wire logic        load_req,
    input  wire logic [15:0] z_ptr,
    input  wire logic [15:0] store_data,
    output logic      [7:0]  load_data,
    output logic             load_valid,
    input  wire logic        eeprom_write_busy,
    input  wire logic [7:0]  fuse_low_byte,
    input  wire logic [7:0]  fuse_high_byte,
    input  wire logic [7:0]  fuse_extended_byte,
    input  wire logic [7:0]  lock_byte,
    output logic             cpu_halt,
    output logic             flash_busy
);
    localparam int unsigned WORDS = 1 << WORD_BITS;
    localparam int unsigned PAGES = 1 << PAGE_BITS;
    localparam int unsigned AW    = WORD_BITS + PAGE_BITS;

    // Page buffer with per-word loaded flags; the array itself lives in the g_page columns.
    logic [15:0]          col_word  [WORDS];
    logic [15:0]          buf_mem   [WORDS];
    logic [WORDS-1:0]     buf_full_reg;

    logic [4:0]           ctl_reg;
    logic [2:0]           win_reg;
    logic [1:0]           lwin_reg;
    fsp_op_e              op_reg = FSP_OP_NONE;
    logic [PAGE_BITS-1:0] op_page_reg;
    logic [7:0]           csr_rdata_reg;
    logic [7:0]           load_data_reg;
    logic                 load_valid_reg;
    logic                 halt_reg;
    logic                 busy_out_reg;
    logic                 timer_busy;
    logic                 timer_done;

    // Pointer split: word offset below the page number; byte select in bit zero. (see [R1])
    wire [WORD_BITS-1:0]  word_sel  = z_ptr[WORD_BITS:1];
    wire [PAGE_BITS-1:0]  page_sel  = z_ptr[AW:WORD_BITS+1];
    wire                  byte_hi   = z_ptr[0]; // see [R3]

    wire [4:0] wr_low   = csr_wdata[4:0];
    wire       legal    = (wr_low == CMD_CLEAR_BUF) || (wr_low == CMD_FUSE_READ)
                       || (wr_low == CMD_PAGE_WRITE) || (wr_low == CMD_PAGE_ERASE)
                       || (wr_low == CMD_LOAD_WORD); // see [R20]
    wire       op_busy  = timer_busy || (op_reg != FSP_OP_NONE);
    // EEPROM writes and a running flash operation lock out new commands. (see [R4]) (see [R21])
    wire       accept   = csr_we && legal && !eeprom_write_busy && !op_busy;
    wire       armed    = ctl_reg[BIT_ENABLE] && (win_reg != 3'h0);
    wire       fuse_arm = armed && ctl_reg[BIT_FUSE_READ] && (lwin_reg != 2'h0);
    wire       do_store = store_req && armed && !ctl_reg[BIT_FUSE_READ] && !op_busy
                       && !eeprom_write_busy; // see [R4]
    wire       do_fuse  = load_req && fuse_arm && !eeprom_write_busy; // see [R4]
    wire       st_erase = do_store && ctl_reg[BIT_ERASE];
    wire       st_write = do_store && ctl_reg[BIT_WRITE];
    wire       st_clear = do_store && ctl_reg[BIT_CLEAR_BUF];
    wire       st_load  = do_store && (ctl_reg == CMD_LOAD_WORD);
    wire       op_start = st_erase || st_write;

    // Fuse and lock bytes pass through unchanged: programmed reads 0, unprogrammed 1. (see [R12])
    logic [7:0] fuse_sel;
    always_comb begin
        case (z_ptr)
            PTR_FUSE_LOW:  fuse_sel = fuse_low_byte;      // see [R9]
            PTR_LOCK:      fuse_sel = lock_byte;          // see [R6]
            PTR_FUSE_EXT:  fuse_sel = fuse_extended_byte; // see [R11]
            PTR_FUSE_HIGH: fuse_sel = fuse_high_byte;     // see [R10]
            default:       fuse_sel = BYTE_ERASED;
        endcase
    end

    wire [15:0] flash_word = col_word[word_sel];
    wire [7:0]  flash_byte = byte_hi ? flash_word[15:8] : flash_word[7:0]; // see [R8]
    // Bit six is the read-while-write busy flag and is tied low. (see [R15])
    wire [7:0]  csr_view   = {3'h0, ctl_reg};

    fsp_op_timer #(
        .CYCLES (WRITE_COUNT)
    ) u_timer (
        .clk   (clk),
        .ce    (ce),
        .start (op_start),
        .busy  (timer_busy),
        .done  (timer_done)
    );

    // Control register and its command windows.
    always_ff @(posedge clk) begin
        if (srst && !op_busy) begin
            ctl_reg  <= CSR_RESET[4:0];
            win_reg  <= 3'h0;
            lwin_reg <= 2'h0;
        end else if (ce) begin
            if (accept) begin
                ctl_reg  <= wr_low;
                win_reg  <= 3'(SPM_WINDOW);
                lwin_reg <= 2'(LPM_WINDOW);
            end else if (op_busy) begin
                // Enable stays high through erase and write, then drops on completion.
                if (timer_done) begin
                    ctl_reg <= CSR_RESET[4:0]; // see [R21]
                end
            end else if (op_start) begin
                win_reg <= 3'h0; // see [R17] see [R19]
            end else if (do_fuse || do_store) begin
                ctl_reg <= CSR_RESET[4:0]; // see [R7]
                win_reg <= 3'h0;
            end else if (win_reg != 3'h0) begin
                win_reg  <= win_reg - 3'h1;
                lwin_reg <= (lwin_reg != 2'h0) ? lwin_reg - 2'h1 : 2'h0;
                if (win_reg == 3'h1 || (ctl_reg[BIT_FUSE_READ] && lwin_reg == 2'h1)) begin
                    ctl_reg <= CSR_RESET[4:0]; // see [R7]
                end
            end
        end
    end

    // Operation sequencing; survives reset so the flash write finishes. (see [R13])
    always_ff @(posedge clk) begin
        if (ce) begin
            if (op_start) begin
                op_reg      <= st_erase ? FSP_OP_ERASE : FSP_OP_WRITE;
                op_page_reg <= page_sel; // see [R2]
            end else if (timer_done) begin
                op_reg <= FSP_OP_NONE;
            end
            halt_reg     <= op_start || (op_busy && !timer_done); // see [R17] see [R19]
            busy_out_reg <= op_start || (op_busy && !timer_done); // see [R21]
        end
    end

    // Page buffer fill flags: cleared by reset, clear command and after page write.
    // Reset leaves them alone while an operation runs, so a page write in flight keeps its data.
    always_ff @(posedge clk) begin
        if (srst && !op_busy) begin
            buf_full_reg <= '0;
        end else if (ce) begin
            if (st_clear || (timer_done && op_reg == FSP_OP_WRITE)) begin
                buf_full_reg <= '0;
            end else if (st_load) begin
                buf_full_reg[word_sel] <= 1'b1; // see [R18]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && st_load && !buf_full_reg[word_sel]) begin
            buf_mem[word_sel] <= store_data; // see [R18]
        end
    end

    // Array update at completion, one page at a time.
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++) begin : g_page
            // One column: word gi of every page, so each process owns its own memory.
            logic [15:0] col_mem [PAGES];
            always_ff @(posedge clk) begin
                if (ce && timer_done) begin
                    if (op_reg == FSP_OP_ERASE) begin
                        col_mem[op_page_reg] <= 16'hffff; // see [R17]
                    end else if (op_reg == FSP_OP_WRITE) begin
                        col_mem[op_page_reg] <= col_mem[op_page_reg]
                            & (buf_full_reg[gi] ? buf_mem[gi] : 16'hffff); // see [R19]
                    end
                end
            end
            assign col_word[gi] = col_mem[page_sel];
        end
    endgenerate

    // Read paths: register read and load program results, one cycle later.
    always_ff @(posedge clk) begin
        if (srst) begin
            csr_rdata_reg  <= 8'h00;
            load_data_reg  <= 8'h00;
            load_valid_reg <= 1'b0;
        end else if (ce) begin
            csr_rdata_reg  <= csr_re ? csr_view : 8'h00;
            load_valid_reg <= load_req;
            if (load_req) begin
                load_data_reg <= do_fuse ? fuse_sel : flash_byte; // see [R3]
            end
        end
    end

    assign csr_rdata  = csr_rdata_reg;
    assign load_data  = load_data_reg;
    assign load_valid = load_valid_reg;
    assign cpu_halt   = halt_reg;
    assign flash_busy = busy_out_reg;
endmodule : fsp_self_prog

// >>> design/fsp_pkg.sv
// Constants for the flash self-programming front end.
// Assumes a 100 MHz core clock and a CPU core that issues store and load program strobes.
package fsp_pkg;
    localparam int unsigned CLK_MHZ          = 100;
    // Flash write time window in microseconds.
    localparam int unsigned WRITE_MIN_US     = 3700;
    localparam int unsigned WRITE_MAX_US     = 4500;
    // Target the midpoint of the window; the count is a parameter default of the top.
    localparam int unsigned WRITE_CYCLES     = ((WRITE_MIN_US + WRITE_MAX_US) / 2) * CLK_MHZ;
    localparam int unsigned SPM_WINDOW       = 4;
    localparam int unsigned LPM_WINDOW       = 3;
    // Control register field positions.
    localparam int unsigned BIT_ENABLE       = 0;
    localparam int unsigned BIT_ERASE        = 1;
    localparam int unsigned BIT_WRITE        = 2;
    localparam int unsigned BIT_FUSE_READ    = 3;
    localparam int unsigned BIT_CLEAR_BUF    = 4;
    localparam int unsigned BIT_RWW_BUSY     = 6;
    // Accepted command patterns in the low five bits.
    localparam logic [4:0]  CMD_CLEAR_BUF    = 5'h11;
    localparam logic [4:0]  CMD_FUSE_READ    = 5'h09;
    localparam logic [4:0]  CMD_PAGE_WRITE   = 5'h05;
    localparam logic [4:0]  CMD_PAGE_ERASE   = 5'h03;
    localparam logic [4:0]  CMD_LOAD_WORD    = 5'h01;
    // Pointer values selecting fuse and lock bytes.
    localparam logic [15:0] PTR_FUSE_LOW     = 16'h0000;
    localparam logic [15:0] PTR_LOCK         = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT     = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH    = 16'h0003;
    localparam logic [7:0]  CSR_RESET        = 8'h00;
    localparam logic [7:0]  BYTE_ERASED      = 8'hff;
    typedef enum logic [1:0] {FSP_OP_NONE, FSP_OP_ERASE, FSP_OP_WRITE} fsp_op_e;
endpackage : fsp_pkg

// >>> design/fsp_op_timer.sv
// Flash operation timer: counts a fixed number of clock cycles per operation.
// Assumes the caller starts it only while idle; srst does not stop a running operation.
`timescale 1ns/1ps
module fsp_op_timer
    import fsp_pkg::*;
#(
    parameter int unsigned CYCLES = WRITE_CYCLES
) (
    input  wire logic clk,
    input  wire logic ce,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    // Reset is deliberately not wired in: a write in flight completes across reset. (see [R13])
    logic [CW-1:0] count_reg = '0;
    logic          busy_reg  = 1'b0;
    logic          done_reg  = 1'b0;
    wire           last      = (count_reg == CW'(1));

    always_ff @(posedge clk) begin
        if (ce) begin
            done_reg <= busy_reg && last;
            if (start && !busy_reg) begin
                busy_reg  <= 1'b1;
                count_reg <= CW'(CYCLES); // see [R14]
            end else if (busy_reg) begin
                count_reg <= count_reg - CW'(1);
                busy_reg  <= !last;
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule : fsp_op_timer

// >>> verif/fsp_cpu_model.sv
// CPU core model issuing store and load program instructions.
// Assumes the bench calls its tasks from one process, right after a clock edge.
`timescale 1ns/1ps
module fsp_cpu_model (
    input  wire logic        clk,
    input  wire logic        flash_busy,
    input  wire logic        load_valid,
    input  wire logic [7:0]  load_data,
    output logic             store_req,
    output logic             load_req,
    output logic      [15:0] z_ptr,
    output logic      [15:0] store_data
);
    initial begin
        store_req = 1'b0;
        load_req = 1'b0;
        z_ptr = 16'h0000;
        store_data = 16'h0000;
    end

    task automatic idle();
        for (int i = 0; i < 200 && flash_busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : idle

    task automatic store(input logic [15:0] p, input logic [15:0] d);
        idle();
        @(posedge clk);
        store_req <= 1'b1;
        z_ptr <= p;
        store_data <= d;
        @(posedge clk);
        store_req <= 1'b0;
        // A released bus shows the inverse, so a stale value cannot pass.
        z_ptr <= ~p;
        store_data <= ~d;
    endtask : store

    task automatic load(input logic [15:0] p, output logic [7:0] r);
        @(posedge clk);
        load_req <= 1'b1;
        z_ptr <= p;
        @(posedge clk);
        load_req <= 1'b0;
        z_ptr <= ~p;
        #1 r = (load_valid === 1'b1) ? load_data : 8'hxx;
    endtask : load
endmodule : fsp_cpu_model

// >>> verif/fsp_self_prog_checker.sv
// Assertions on the ports of the flash self-programming front end.
// Assumes one clock domain with synchronous reset srst.
`timescale 1ns/1ps
module fsp_self_prog_checker
    import fsp_pkg::*;
#(
    parameter int unsigned WRITE_COUNT = WRITE_CYCLES
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        ce,
    input wire logic        csr_we,
    input wire logic [7:0]  csr_wdata,
    input wire logic [7:0]  csr_rdata,
    input wire logic        store_req,
    input wire logic        load_req,
    input wire logic [15:0] z_ptr,
    input wire logic [7:0]  load_data,
    input wire logic        load_valid,
    input wire logic        eeprom_write_busy,
    input wire logic [7:0]  fuse_low_byte,
    input wire logic [7:0]  lock_byte,
    input wire logic        cpu_halt,
    input wire logic        flash_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // A running operation survives reset, so this counter ignores srst.
    int busy_cnt = 0;
    always_ff @(posedge clk) begin
        if (!flash_busy) busy_cnt <= 0;
        else if (ce) busy_cnt <= busy_cnt + 1;
    end
    chk_halt_busy_same: assert property (cpu_halt == flash_busy)
        else $error("halt and busy differ");
    chk_busy_span: assert property (
        $fell(flash_busy) |-> busy_cnt == WRITE_COUNT + 1)
        else $error("operation length wrong");
    chk_halt_cause: assert property (
        $rose(flash_busy) |-> $past(store_req) && $past(ce))
        else $error("operation began without a store");
    chk_eeprom_block: assert property (
        (!flash_busy && eeprom_write_busy) [*6] |=> !flash_busy)
        else $error("operation began during eeprom write");
    chk_load_pulse: assert property (ce |=> load_valid == $past(load_req))
        else $error("load answer timing wrong");
    chk_rww_zero: assert property (csr_rdata[7:5] == 3'h0)
        else $error("reserved or busy bit set");
    chk_fuse_low: assert property (
        csr_we && ce && csr_wdata[4:0] == CMD_FUSE_READ && !eeprom_write_busy && !flash_busy
        ##1 ce && !csr_we && !load_req
        ##1 ce && load_req && z_ptr == PTR_FUSE_LOW && !eeprom_write_busy
        |=> load_data == $past(fuse_low_byte)) else $error("fuse low byte wrong");
    chk_lock_read: assert property (csr_we && ce && csr_wdata[4:0] == CMD_FUSE_READ
        && !eeprom_write_busy && !flash_busy ##1 ce && !csr_we && !load_req
        ##1 ce && load_req && z_ptr == PTR_LOCK && !eeprom_write_busy
        |=> load_data == $past(lock_byte)) else $error("lock byte wrong");
endmodule : fsp_self_prog_checker

bind fsp_self_prog fsp_self_prog_checker #(.WRITE_COUNT(WRITE_COUNT)) fsp_self_prog_checker_i (
    .clk, .srst, .ce, .csr_we, .csr_wdata, .csr_rdata, .store_req, .load_req, .z_ptr,
    .load_data, .load_valid, .eeprom_write_busy, .fuse_low_byte, .lock_byte, .cpu_halt,
    .flash_busy);

// >>> verif/test_fsp_self_prog.sv
// Self-checking bench for the flash self-programming front end.
// Assumes the CPU model of fsp_cpu_model.sv and a short operation count.
`timescale 1ns/1ps
module test_fsp_self_prog
    import fsp_pkg::*;
;
    localparam int unsigned WC = 20;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic        csr_we = 1'b0;
    logic        csr_re = 1'b0;
    logic        eeprom_write_busy = 1'b0;
    logic [7:0]  csr_wdata = 8'h00;
    logic [7:0]  fuse_low_byte = 8'h00;
    logic [7:0]  fuse_high_byte = 8'h00;
    logic [7:0]  fuse_extended_byte = 8'h00;
    logic [7:0]  lock_byte = 8'h00;
    logic [7:0]  csr_rdata, load_data, v;
    logic        load_valid, store_req, load_req, cpu_halt, flash_busy;
    logic [15:0] z_ptr, store_data, d1, d2;
    logic [31:0] seed = 32'hcb07777b;
    logic [31:0] r;
    logic [3:0]  pg;
    logic [4:0]  ofs;
    logic [4:0]  codes [9] = '{5'h11, 5'h09, 5'h05, 5'h03, 5'h01, 5'h00, 5'h1f, 5'h07, 5'h19};
    int          errors = 0;
    int          checks_done = 0;
    int          cyc = 0;

    always #5 clk = ~clk;

    fsp_self_prog #(.WRITE_COUNT(WC)) fsp_self_prog_i (.clk, .srst, .ce, .csr_we, .csr_re,
        .csr_wdata, .csr_rdata, .store_req, .load_req, .z_ptr, .store_data, .load_data,
        .load_valid, .eeprom_write_busy, .fuse_low_byte, .fuse_high_byte, .fuse_extended_byte,
        .lock_byte, .cpu_halt, .flash_busy);
    fsp_cpu_model fsp_cpu_model_i (.clk, .flash_busy, .load_valid, .load_data, .store_req,
        .load_req, .z_ptr, .store_data);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] zp(input logic [3:0] p, input logic [4:0] w, input logic b);
        return {6'h00, p, w, b};
    endfunction : zp
    function automatic logic [7:0] fuse_exp(input logic [1:0] p);
        return p == 2'h0 ? fuse_low_byte : p == 2'h1 ? lock_byte :
               p == 2'h2 ? fuse_extended_byte : fuse_high_byte;
    endfunction : fuse_exp

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] w);
        @(posedge clk);
        csr_we <= 1'b1;
        csr_wdata <= w;
        @(posedge clk);
        csr_we <= 1'b0;
        csr_wdata <= ~w;
    endtask : wr
    task automatic rd(output logic [7:0] q);
        @(posedge clk);
        csr_re <= 1'b1;
        @(posedge clk);
        csr_re <= 1'b0;
        #1 q = csr_rdata;
    endtask : rd
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors = errors + 1;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        r = rnd();
        srst <= 1'b0;
        {fuse_low_byte, fuse_high_byte, fuse_extended_byte, lock_byte} <= r;
        rd(v);
        check(v, CSR_RESET);
        for (int i = 0; i < 9; i++) begin
            r = rnd();
            wr({r[7:5], codes[i]});
            rd(v);
            check(v, i < 5 ? {3'h0, codes[i]} : 8'h00);
            repeat (5) @(posedge clk);
            rd(v);
            check(v, 8'h00);
        end
        for (int p = 0; p < 4; p++) begin
            wr({3'h0, CMD_FUSE_READ});
            fsp_cpu_model_i.load(16'(p), v);
            check(v, fuse_exp(2'(p)));
            rd(v);
            check(v, 8'h00);
        end
        // A low clock enable freezes the store window, so the command is still armed.
        wr({3'h0, CMD_LOAD_WORD});
        ce <= 1'b0;
        repeat (6) @(posedge clk);
        ce <= 1'b1;
        rd(v);
        check(v, {3'h0, CMD_LOAD_WORD});
        r = rnd();
        pg = r[3:0];
        ofs = r[8:4];
        wr({3'h0, CMD_PAGE_ERASE});
        fsp_cpu_model_i.store(zp(pg, ofs, 1'b1), r[31:16]);
        #1 check({6'h00, cpu_halt, flash_busy}, 8'h03);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1 check({7'h00, flash_busy}, 8'h01);
        wr({3'h0, CMD_LOAD_WORD});
        rd(v);
        check(v, 8'h03);
        fsp_cpu_model_i.idle();
        rd(v);
        check(v, 8'h00);
        fsp_cpu_model_i.load(zp(pg, ofs, 1'b0), v);
        check(v, BYTE_ERASED);
        r = rnd();
        d1 = r[15:0];
        d2 = r[31:16];
        wr({3'h0, CMD_LOAD_WORD});
        fsp_cpu_model_i.store(zp(pg, ofs, 1'b0), d1);
        wr({3'h0, CMD_LOAD_WORD});
        fsp_cpu_model_i.store(zp(pg, ofs + 5'h01, 1'b0), d2);
        wr({3'h0, CMD_PAGE_WRITE});
        fsp_cpu_model_i.store(zp(pg, 5'h00, 1'b0), 16'h0000);
        #1 check({6'h00, cpu_halt, flash_busy}, 8'h03);
        fsp_cpu_model_i.idle();
        for (int i = 0; i < 4; i++) begin
            fsp_cpu_model_i.load(zp(pg, ofs + 5'(i / 2), i[0]), v);
            check(v, 8'({d2, d1} >> (8 * i)));
        end
        // An EEPROM write that starts inside an armed fuse read turns the load into a flash read.
        wr({3'h0, CMD_FUSE_READ});
        eeprom_write_busy <= 1'b1;
        fsp_cpu_model_i.load(zp(pg, ofs, 1'b0), v);
        check(v, d1[7:0]);
        wr({3'h0, CMD_PAGE_ERASE});
        fsp_cpu_model_i.store(zp(pg, ofs, 1'b0), 16'h0000);
        #1 check({7'h00, flash_busy}, 8'h00);
        repeat (8) @(posedge clk);
        eeprom_write_busy <= 1'b0;
        // Once the EEPROM write is over, the control register takes commands again.
        wr({3'h0, CMD_PAGE_ERASE});
        rd(v);
        check(v, {3'h0, CMD_PAGE_ERASE});
        end_of_test();
    end
endmodule : test_fsp_self_prog
